// [rtl/smw_pkg.sv]
// shared constants and types for the static memory write/page timing block
package smw_pkg;
	localparam int SMW_CS_NUM = 4;
	localparam int SMW_CS_W = 2;
	localparam int SMW_ADDR_W = 24;
	localparam int SMW_DATA_W = 16;
	localparam int SMW_CNT_W = 8;
	// page size in address bits (8-word pages)
	localparam int SMW_PAGE_LSB = 3;
	localparam logic [SMW_CNT_W-1:0] SMW_CNT_ZERO = 8'h00;
	localparam logic [SMW_CNT_W-1:0] SMW_CNT_ONE = 8'h01;
	localparam logic [SMW_ADDR_W-1:0] SMW_ADDR_RST = 24'h000000;
	localparam logic [SMW_DATA_W-1:0] SMW_DATA_RST = 16'h0000;
	typedef enum logic [1:0] {
		SMW_IDLE,
		SMW_WRITE,
		SMW_READ
	} smw_state_t;
endpackage

// [rtl/smw_phase.sv]
// one strobe phase generator: low from setup to setup+pulse
`timescale 1ns/1ns
module smw_phase
	import smw_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [SMW_CNT_W-1:0] setup_cycles,
	input wire logic [SMW_CNT_W-1:0] pulse_cycles,
	input wire logic [SMW_CNT_W-1:0] count,
	output logic strobe_n
);
	logic [SMW_CNT_W:0] fall_at;
	logic [SMW_CNT_W:0] rise_at;
	logic next_strobe_n;

	// compare against the shared cycle counter, one edge early
	assign fall_at = {1'b0, setup_cycles};
	assign rise_at = {1'b0, setup_cycles} + {1'b0, pulse_cycles};
	assign next_strobe_n = !(({1'b0, count} >= fall_at) &&
		({1'b0, count} < rise_at));

	// registered output so the pin never glitches
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_n <= 1'b1;
		end else if (start) begin
			strobe_n <= (setup_cycles != SMW_CNT_ZERO) ||
				(pulse_cycles == SMW_CNT_ZERO);
		end else begin
			strobe_n <= next_strobe_n;
		end
	end
endmodule

// [rtl/smw_ctrl.sv]
// static memory controller write waveforms and page-mode read timing
`timescale 1ns/1ns
module smw_ctrl
	import smw_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [SMW_CS_W-1:0] req_cs,
	input wire logic [SMW_ADDR_W-1:0] req_addr,
	input wire logic [SMW_DATA_W-1:0] req_wdata,
	input wire logic other_access,
	input wire logic [SMW_CS_NUM-1:0] page_mode,
	input wire logic cfg_write,
	input wire logic [SMW_CS_W-1:0] cfg_cs,
	input wire logic [SMW_CNT_W-1:0] wr_strobe_setup_cycles,
	input wire logic [SMW_CNT_W-1:0] wr_strobe_pulse_cycles,
	input wire logic [SMW_CNT_W-1:0] cs_write_setup_cycles,
	input wire logic [SMW_CNT_W-1:0] cs_write_pulse_cycles,
	input wire logic [SMW_CNT_W-1:0] write_total_cycles,
	input wire logic [SMW_CNT_W-1:0] cs_read_pulse_cycles,
	input wire logic [SMW_CNT_W-1:0] rd_strobe_pulse_cycles,
	input wire logic [SMW_DATA_W-1:0] mem_rdata,
	output logic req_ready,
	output logic done,
	output logic [SMW_DATA_W-1:0] rdata,
	output logic page_hit,
	output logic [SMW_ADDR_W-1:0] mem_addr,
	output logic [SMW_DATA_W-1:0] mem_wdata,
	output logic mem_wdata_oe,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic [SMW_CS_NUM-1:0] chip_select_n,
	output logic [SMW_CNT_W-1:0] wr_strobe_hold_cycles,
	output logic [SMW_CNT_W-1:0] cs_write_hold_cycles
);
	// per chip select timing tables
	logic [SMW_CNT_W-1:0] we_setup_tab [SMW_CS_NUM];
	logic [SMW_CNT_W-1:0] we_pulse_tab [SMW_CS_NUM];
	logic [SMW_CNT_W-1:0] cs_setup_tab [SMW_CS_NUM];
	logic [SMW_CNT_W-1:0] cs_pulse_tab [SMW_CS_NUM];
	logic [SMW_CNT_W-1:0] total_tab [SMW_CS_NUM];
	// page read times; the other read timings have no effect
	logic [SMW_CNT_W-1:0] tpa_tab [SMW_CS_NUM];
	logic [SMW_CNT_W-1:0] tsa_tab [SMW_CS_NUM];

	smw_state_t state;
	logic [SMW_CS_W-1:0] cur_cs;
	logic [SMW_CNT_W-1:0] count;
	logic [SMW_CNT_W-1:0] end_count;
	logic page_valid;
	logic [SMW_CS_W-1:0] last_cs;
	logic [SMW_ADDR_W-SMW_PAGE_LSB-1:0] last_page;

	// request decode and sequencing
	logic start;
	logic start_wr;
	logic start_rd;
	logic hit;
	logic last_cycle;
	logic [SMW_CNT_W-1:0] rd_len;
	logic [SMW_CNT_W-1:0] wr_len;
	logic [SMW_CS_NUM-1:0] cs_onehot;
	// phase generator controls, shared by strobe and selects
	logic [SMW_CS_W-1:0] sel_cs;
	logic wr_mode;
	logic run;
	logic wr_run;
	logic [SMW_CNT_W-1:0] next_count;
	logic [SMW_CNT_W-1:0] we_setup_sel;
	logic [SMW_CNT_W-1:0] we_pulse_sel;
	logic [SMW_CNT_W-1:0] cs_setup_sel;
	logic [SMW_CNT_W-1:0] cs_pulse_sel;
	// per chip pulse, zero for chips not addressed
	logic [SMW_CNT_W-1:0] cs_pulse_chip [SMW_CS_NUM];

	// hold = total - setup - pulse, truncated to counter width
	function automatic logic [SMW_CNT_W-1:0] hold_of(
		input logic [SMW_CNT_W-1:0] total,
		input logic [SMW_CNT_W-1:0] setup,
		input logic [SMW_CNT_W-1:0] pulse
	);
		hold_of = total - setup - pulse;
	endfunction

	// a zero length cycle still occupies one clock
	function automatic logic [SMW_CNT_W-1:0] len_of(
		input logic [SMW_CNT_W-1:0] cycles
	);
		len_of = (cycles == SMW_CNT_ZERO) ? SMW_CNT_ONE : cycles;
	endfunction

	// request decode
	assign start = (state == SMW_IDLE) && req_valid;
	assign start_wr = start && req_write;
	assign start_rd = start && !req_write;
	assign hit = page_valid && (last_cs == req_cs) &&
		(last_page == req_addr[SMW_ADDR_W-1:SMW_PAGE_LSB]);
	assign rd_len = len_of(hit ? tsa_tab[req_cs] : tpa_tab[req_cs]);
	assign wr_len = len_of(total_tab[req_cs]);
	assign last_cycle = (state != SMW_IDLE) &&
		(count == end_count - SMW_CNT_ONE);
	// the access being started wins over the one in flight
	assign sel_cs = start ? req_cs : cur_cs;
	assign wr_mode = start ? req_write : (state == SMW_WRITE);
	// run covers the taking edge up to, not including, the closing edge
	assign run = start || ((state != SMW_IDLE) && !last_cycle);
	assign wr_run = run && wr_mode;
	// cycle index that the phase generators see after the edge
	assign next_count = (state != SMW_IDLE) ? count + SMW_CNT_ONE :
		SMW_CNT_ZERO;
	// one-hot select of the addressed chip
	assign cs_onehot = SMW_CS_NUM'(1) << sel_cs;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < SMW_CS_NUM; i++) begin
				we_setup_tab[i] <= SMW_CNT_ZERO;
				we_pulse_tab[i] <= SMW_CNT_ZERO;
				cs_setup_tab[i] <= SMW_CNT_ZERO;
				cs_pulse_tab[i] <= SMW_CNT_ZERO;
				total_tab[i] <= SMW_CNT_ZERO;
				tpa_tab[i] <= SMW_CNT_ZERO;
				tsa_tab[i] <= SMW_CNT_ZERO;
			end
		end else if (cfg_write) begin
			we_setup_tab[cfg_cs] <= wr_strobe_setup_cycles;
			we_pulse_tab[cfg_cs] <= wr_strobe_pulse_cycles;
			cs_setup_tab[cfg_cs] <= cs_write_setup_cycles;
			cs_pulse_tab[cfg_cs] <= cs_write_pulse_cycles;
			total_tab[cfg_cs] <= write_total_cycles;
			tpa_tab[cfg_cs] <= cs_read_pulse_cycles;
			tsa_tab[cfg_cs] <= rd_strobe_pulse_cycles;
		end
	end

	// wraps when setup plus pulse exceed the programmed total
	// derived hold intervals for the chip being configured
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_strobe_hold_cycles <= SMW_CNT_ZERO;
			cs_write_hold_cycles <= SMW_CNT_ZERO;
		end else begin
			wr_strobe_hold_cycles <= hold_of(total_tab[cfg_cs],
				we_setup_tab[cfg_cs], we_pulse_tab[cfg_cs]);
			cs_write_hold_cycles <= hold_of(total_tab[cfg_cs],
				cs_setup_tab[cfg_cs], cs_pulse_tab[cfg_cs]);
		end
	end

	// sequencer and shared cycle counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= SMW_IDLE;
			count <= SMW_CNT_ZERO;
			end_count <= SMW_CNT_ONE;
			cur_cs <= '0;
		end else begin
			case (state)
				SMW_IDLE: begin
					count <= SMW_CNT_ZERO;
					if (start_wr) begin
						state <= SMW_WRITE;
						end_count <= wr_len;
						cur_cs <= req_cs;
					end else if (start_rd) begin
						state <= SMW_READ;
						end_count <= rd_len;
						cur_cs <= req_cs;
					end
				end
				default: begin
					// one total length for both waves
					if (last_cycle) begin
						state <= SMW_IDLE;
					end
					count <= count + SMW_CNT_ONE;
				end
			endcase
		end
	end

	// address and data stay until cycle end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_addr <= SMW_ADDR_RST;
			mem_wdata <= SMW_DATA_RST;
			mem_wdata_oe <= 1'b0;
		end else if (start) begin
			mem_addr <= req_addr;
			mem_wdata <= req_wdata;
			mem_wdata_oe <= req_write;
		// data bus released as the write cycle closes
		end else if (last_cycle) begin
			mem_wdata_oe <= 1'b0;
		end
	end

	// zero pulse outside a run parks every phase output high
	assign we_setup_sel = we_setup_tab[sel_cs];
	assign we_pulse_sel = wr_run ? we_pulse_tab[sel_cs] : SMW_CNT_ZERO;
	// reads hold the select low over the whole access
	assign cs_setup_sel = wr_mode ? cs_setup_tab[sel_cs] : SMW_CNT_ZERO;
	assign cs_pulse_sel = wr_mode ? cs_pulse_tab[sel_cs] :
		(start ? rd_len : end_count);

	// write strobe timed from setup and pulse
	smw_phase u_we (
		.clk(clk),
		.reset_n(reset_n),
		.start(start_wr),
		.setup_cycles(we_setup_sel),
		.pulse_cycles(we_pulse_sel),
		.count(next_count),
		.strobe_n(write_strobe_n)
	);

	// one select generator per chip, others parked high
	for (genvar j = 0; j < SMW_CS_NUM; j++) begin : g_cs
		assign cs_pulse_chip[j] = (cs_onehot[j] && run) ? cs_pulse_sel :
			SMW_CNT_ZERO;
		smw_phase u_cs (
			.clk(clk),
			.reset_n(reset_n),
			.start(start),
			.setup_cycles(cs_setup_sel),
			.pulse_cycles(cs_pulse_chip[j]),
			.count(next_count),
			.strobe_n(chip_select_n[j])
		);
	end

	// read strobe low from the taking edge to the closing edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read_strobe_n <= 1'b1;
		end else begin
			read_strobe_n <= !(run && !wr_mode);
		end
	end

	// page tracker: last chip select and page address
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			page_valid <= 1'b0;
			last_cs <= '0;
			last_page <= '0;
		end else if (other_access || start_wr) begin
			page_valid <= 1'b0;
		// remember chip and page of this read
		end else if (start_rd) begin
			page_valid <= page_mode[req_cs];
			last_cs <= req_cs;
			last_page <= req_addr[SMW_ADDR_W-1:SMW_PAGE_LSB];
		end
	end

	// answer side
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_ready <= 1'b0;
			done <= 1'b0;
			rdata <= SMW_DATA_RST;
			page_hit <= 1'b0;
		end else begin
			req_ready <= (state == SMW_IDLE) && !req_valid;
			done <= last_cycle;
			// sampled while the read strobe is still low
			if (last_cycle && state == SMW_READ) begin
				rdata <= mem_rdata;
			end
			if (start_rd) begin
				page_hit <= hit;
			end
		end
	end
endmodule

// [verification/smw_monitor.sv]
// port checker for the static memory write and page block
`timescale 1ns/1ns
module smw_monitor
	import smw_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cfg_write,
	input wire logic [SMW_CNT_W-1:0] wr_strobe_setup_cycles,
	input wire logic [SMW_CNT_W-1:0] wr_strobe_pulse_cycles,
	input wire logic [SMW_CNT_W-1:0] cs_write_setup_cycles,
	input wire logic [SMW_CNT_W-1:0] cs_write_pulse_cycles,
	input wire logic [SMW_CNT_W-1:0] write_total_cycles,
	input wire logic req_ready,
	input wire logic done,
	input wire logic [SMW_ADDR_W-1:0] mem_addr,
	input wire logic mem_wdata_oe,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [SMW_CS_NUM-1:0] chip_select_n,
	input wire logic [SMW_CNT_W-1:0] wr_strobe_hold_cycles,
	input wire logic [SMW_CNT_W-1:0] cs_write_hold_cycles
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// holds follow a table load within two cycles
	property p_ws_hold; cfg_write |-> ##[1:2] wr_strobe_hold_cycles ==
		write_total_cycles - wr_strobe_setup_cycles - wr_strobe_pulse_cycles;
	endproperty
	a_ws_hold: assert property (p_ws_hold) else $error("bad strobe hold");
	property p_cs_hold; cfg_write |-> ##[1:2] cs_write_hold_cycles ==
		write_total_cycles - cs_write_setup_cycles - cs_write_pulse_cycles;
	endproperty
	a_cs_hold: assert property (p_cs_hold) else $error("bad cs hold");
	property p_addr; !write_strobe_n |=> $stable(mem_addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_data; !write_strobe_n |-> mem_wdata_oe; endproperty
	a_data: assert property (p_data) else $error("data not driven");
	property p_done; done |=> !done; endproperty
	a_done: assert property (p_done) else $error("done too long");
	property p_excl; write_strobe_n || read_strobe_n; endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_idle; req_ready |-> write_strobe_n && read_strobe_n; endproperty
	a_idle: assert property (p_idle) else $error("strobe when idle");
	property p_end; done |-> write_strobe_n; endproperty
	a_end: assert property (p_end) else $error("strobe past cycle");
	property p_cs_one; $onehot0(~chip_select_n); endproperty
	a_cs_one: assert property (p_cs_one) else $error("two selects low");
	property p_cs_addr; !(&chip_select_n) |=> $stable(mem_addr); endproperty
	a_cs_addr: assert property (p_cs_addr) else $error("addr moved");
	c_cs: cover property ($fell(chip_select_n[0]));
	c_cfg: cover property (cfg_write);
	c_wr: cover property ($fell(write_strobe_n));
	c_done: cover property (done);
endmodule
bind smw_ctrl smw_monitor i_smw_monitor (.*);

// [verification/smw_mem_model.sv]
// behavioural static memory on the far side
`timescale 1ns/1ns
module smw_mem_model
	import smw_pkg::*;
(
	input wire logic [SMW_ADDR_W-1:0] mem_addr,
	input wire logic [SMW_DATA_W-1:0] mem_wdata,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	output logic [SMW_DATA_W-1:0] mem_rdata
);
	logic [SMW_DATA_W-1:0] cells [16];
	logic [SMW_DATA_W-1:0] last;
	initial begin
		foreach (cells[i]) cells[i] = SMW_DATA_RST;
		last = SMW_DATA_RST;
	end
	// data still valid at strobe rise
	always @(posedge write_strobe_n) begin
		cells[mem_addr[3:0]] <= mem_wdata;
	end
	always @(posedge read_strobe_n) begin
		last <= cells[mem_addr[3:0]];
	end
	// no wait line; released bus shows inverse of last word
	assign mem_rdata = read_strobe_n ? ~last : cells[mem_addr[3:0]];
endmodule

// [verification/testbench.sv]
// self-checking bench for the static memory write and page block
`timescale 1ns/1ns
module testbench;
	import smw_pkg::*;
	logic clk, reset_n, req_valid, req_write, other_access, cfg_write;
	logic [SMW_CS_W-1:0] req_cs, cfg_cs;
	logic [SMW_ADDR_W-1:0] req_addr, mem_addr;
	logic [SMW_DATA_W-1:0] req_wdata, mem_rdata, rdata, mem_wdata;
	logic [SMW_CS_NUM-1:0] page_mode, chip_select_n;
	logic [SMW_CNT_W-1:0] wr_strobe_setup_cycles, wr_strobe_pulse_cycles;
	logic [SMW_CNT_W-1:0] cs_write_setup_cycles, cs_write_pulse_cycles;
	logic [SMW_CNT_W-1:0] write_total_cycles, cs_read_pulse_cycles;
	logic [SMW_CNT_W-1:0] rd_strobe_pulse_cycles, wr_strobe_hold_cycles;
	logic [SMW_CNT_W-1:0] cs_write_hold_cycles;
	logic req_ready, done, page_hit, mem_wdata_oe, write_strobe_n;
	logic read_strobe_n;
	int bad_count, num_checks, n_set, n_low, n_done, n_cset, n_clow;
	smw_ctrl i_smw_ctrl (.*);
	smw_mem_model i_smw_mem_model (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one access; counts setup and low cycles of strobe and select
	task automatic acc(logic w, logic [1:0] cs, logic [23:0] a, d);
		@(negedge clk);
		{req_valid, req_write, req_cs} = {1'b1, w, cs};
		{req_addr, req_wdata} = {a, d[15:0]};
		@(negedge clk);
		req_valid = 1'b0;
		{n_set, n_low, n_done, n_cset, n_clow} = 0;
		for (int n = 1; n < 100 && n_done == 0; n++) begin
			if (write_strobe_n === 1'b0) n_low++;
			else if (n_low == 0) n_set++;
			if (chip_select_n[cs] === 1'b0) n_clow++;
			else if (n_clow == 0) n_cset++;
			if (done === 1'b1) n_done = n;
			else @(negedge clk);
		end
		if (n_done == 0) begin
			chk("access timeout", 24'h1, 24'h0);
			tally_and_finish;
		end
		chk("select released", chip_select_n, 24'h00000F);
	endtask
	task automatic t_write;
		logic [39:0] tab [2] = '{40'h0203010508, 40'h0101010204};
		logic [23:0] exp_ws, exp_cs;
		for (int i = 0; i < 2; i++) begin
			@(negedge clk);
			{wr_strobe_setup_cycles, wr_strobe_pulse_cycles,
				cs_write_setup_cycles, cs_write_pulse_cycles,
				write_total_cycles} = tab[i];
			{cfg_write, cfg_cs} = {1'b1, 2'(i + 1)};
			@(negedge clk);
			cfg_write = 1'b0;
			@(negedge clk);
			exp_ws = tab[i][7:0] - tab[i][39:32] - tab[i][31:24];
			exp_cs = tab[i][7:0] - tab[i][23:16] - tab[i][15:8];
			chk("ws hold", wr_strobe_hold_cycles, exp_ws);
			chk("cs hold", cs_write_hold_cycles, exp_cs);
		end
		for (int i = 0; i < 2; i++) begin
			acc(1'b1, 2'(i + 1), 24'h000019 - 24'(i * 23), 24'h00C3A5);
			chk("write setup", n_set, tab[i][39:32]);
			chk("write pulse", n_low, tab[i][31:24]);
			chk("cs setup", n_cset, tab[i][23:16]);
			chk("cs pulse", n_clow, tab[i][15:8]);
			chk("write total", n_done, tab[i][7:0] + 1);
		end
		$display("write test done");
	endtask
	task automatic t_page;
		logic [31:0] seq [6] = '{32'h00000010, 32'h00100015, 32'h00100012,
			32'h00000018, 32'h10000018, 32'h11000019};
		// chip 0 was never loaded; give it the page read times
		@(negedge clk);
		{cfg_write, cfg_cs} = {1'b1, 2'h0};
		@(negedge clk);
		cfg_write = 1'b0;
		foreach (seq[i]) begin
			@(negedge clk);
			other_access = seq[i][24];
			@(negedge clk);
			other_access = 1'b0;
			acc(1'b0, seq[i][29:28], {4'h0, seq[i][19:0]}, 24'h0);
			chk("page hit", page_hit, seq[i][20]);
			chk("read time", n_done, seq[i][20] ? 6 : 3);
			chk("read select", n_clow, seq[i][20] ? 5 : 2);
		end
		chk("read data", rdata, 24'h00C3A5);
		$display("page test done");
	endtask
	initial begin
		{reset_n, req_valid, req_write, other_access, cfg_write} = 0;
		{req_cs, cfg_cs, req_addr, req_wdata} = 0;
		page_mode = 4'hF;
		{wr_strobe_setup_cycles, wr_strobe_pulse_cycles} = 0;
		{cs_write_setup_cycles, cs_write_pulse_cycles} = 0;
		write_total_cycles = 8'h01;
		// short open time 2 below long in-page time 5
		cs_read_pulse_cycles = 8'h02;
		rd_strobe_pulse_cycles = 8'h05;
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		t_write;
		t_page;
		tally_and_finish;
	end
endmodule
